// file: design/gdio_port.sv
// general digital io port: apb registers, pin drive and pull-up control
// Function
// - Each port has direction, output-value (both read/write) and read-only pin-input registers.
// - Pull-up kill bit set disables every pull-up, whatever each pin says.
// - Direction bit one makes the pin an output, zero an input.
// - Input pin with output-value one gets pull-up; clear or output turns it off.
// - Every pin is high impedance while reset is active, even without clock.
// - Output pin drives high for output-value one, low for zero.
// - Software never jumps directly between tri-state and output high; the port does not enforce this and decodes every step as written.
// - Pull-up on only for direction zero, value one, kill zero; else high impedance.
// - Pin-input register reads synchronised pin level regardless of direction.
// - Input passes latch open while clock high, then rising-edge input register.
// - Software-set pin level reaches the input register one clock period later.
// - Single-bit set and clear change only the addressed pin.
// - Deep sleep with io and converter clocks stopped disables input buffers, except wake and alternate-function pins.
// - Alternate function on some pins leaves the others usable as plain io.
// - Pull-up kill is bit 6 of system control, resets zero, read/write.
`timescale 1ns/1ps
`default_nettype none
module gdio_port #(
    parameter int PIN_W = 8
) (
    // clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // apb slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [gdio_pkg::ADDR_W-1:0] paddr,
    input  wire logic [gdio_pkg::DATA_W-1:0] pwdata,
    output logic      [gdio_pkg::DATA_W-1:0] prdata,
    output logic                             pready,
    output logic                             pslverr,
    // pins
    input  wire logic [PIN_W-1:0]            pin_in,
    output logic      [PIN_W-1:0]            pin_out,
    output logic      [PIN_W-1:0]            pin_oe,
    output logic      [PIN_W-1:0]            pin_pu,
    // sleep state
    input  wire logic                        io_clk_stop,
    input  wire logic                        adc_clk_stop,
    // alternate function takeover per pin
    input  wire logic [PIN_W-1:0]            alt_en,
    input  wire logic [PIN_W-1:0]            alt_oe,
    input  wire logic [PIN_W-1:0]            alt_out
);
    typedef struct packed {
        logic [PIN_W-1:0]            dir;
        logic [PIN_W-1:0]            outv;
        logic [PIN_W-1:0]            wake;
        logic                        kill;
        logic [PIN_W-1:0]            oe;
        logic [PIN_W-1:0]            drv;
        logic [PIN_W-1:0]            pu;
        logic [gdio_pkg::DATA_W-1:0] rdata;
        logic                        ready;
        logic                        err;
    } gdio_state_t;

    gdio_state_t      st_r;
    gdio_state_t      st_nxt;
    logic             deep_sleep;
    logic [PIN_W-1:0] in_enable;
    logic [PIN_W-1:0] sample;
    logic [PIN_W-1:0] wmask;
    logic             wr_go;
    logic             rd_setup;
    logic             mapped;

    gdio_sync_if #(.PIN_W(PIN_W)) sif ();

    assign deep_sleep = io_clk_stop & adc_clk_stop;
    assign in_enable  = ~{PIN_W{deep_sleep}} | st_r.wake | alt_en;
    // clamped to ground, so a floating pin burns no input current
    assign sif.level  = pin_in & in_enable;
    assign sample     = sif.sample;

    gdio_sync #(.PIN_W(PIN_W)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .sif     (sif.sync_side)
    );

    assign wmask    = pwdata[PIN_W-1:0];
    assign wr_go    = psel & penable & pwrite & st_r.ready;
    assign rd_setup = psel & ~penable;

    always_comb
    begin
        st_nxt = st_r;
        unique case (paddr)
            gdio_pkg::OFS_DIRECTION,
            gdio_pkg::OFS_OUT_VALUE,
            gdio_pkg::OFS_PIN_INPUT,
            gdio_pkg::OFS_SYS_CTRL,
            gdio_pkg::OFS_DIR_SET,
            gdio_pkg::OFS_DIR_CLR,
            gdio_pkg::OFS_OUT_SET,
            gdio_pkg::OFS_OUT_CLR,
            gdio_pkg::OFS_WAKE_KEEP: mapped = 1'b1;
            default:                 mapped = 1'b0;
        endcase
        // register writes at the access edge
        if (wr_go)
        begin
            unique case (paddr)
                gdio_pkg::OFS_DIRECTION: st_nxt.dir  = wmask;
                gdio_pkg::OFS_OUT_VALUE: st_nxt.outv = wmask;
                gdio_pkg::OFS_SYS_CTRL:  st_nxt.kill = pwdata[gdio_pkg::KILL_BIT];
                gdio_pkg::OFS_DIR_SET:   st_nxt.dir  = st_r.dir | wmask;
                gdio_pkg::OFS_DIR_CLR:   st_nxt.dir  = st_r.dir & ~wmask;
                gdio_pkg::OFS_OUT_SET:   st_nxt.outv = st_r.outv | wmask;
                gdio_pkg::OFS_OUT_CLR:   st_nxt.outv = st_r.outv & ~wmask;
                gdio_pkg::OFS_WAKE_KEEP: st_nxt.wake = wmask;
                default:                 st_nxt.dir  = st_r.dir;
            endcase
        end
        // zero-wait slave: answer prepared during setup
        st_nxt.ready = rd_setup;
        st_nxt.err   = rd_setup & ~mapped;
        st_nxt.rdata = gdio_pkg::RDATA_RST;
        if (rd_setup && !pwrite)
        begin
            unique case (paddr)
                gdio_pkg::OFS_DIRECTION,
                gdio_pkg::OFS_DIR_SET,
                gdio_pkg::OFS_DIR_CLR:   st_nxt.rdata[PIN_W-1:0] = st_r.dir;
                gdio_pkg::OFS_OUT_VALUE,
                gdio_pkg::OFS_OUT_SET,
                gdio_pkg::OFS_OUT_CLR:   st_nxt.rdata[PIN_W-1:0] = st_r.outv;
                // pin level read regardless of direction
                gdio_pkg::OFS_PIN_INPUT: st_nxt.rdata[PIN_W-1:0] = sample;
                gdio_pkg::OFS_SYS_CTRL:  st_nxt.rdata[gdio_pkg::KILL_BIT] = st_r.kill;
                gdio_pkg::OFS_WAKE_KEEP: st_nxt.rdata[PIN_W-1:0] = st_r.wake;
                default:                 st_nxt.rdata = gdio_pkg::RDATA_RST;
            endcase
        end
        // direction decides driver; takeover only on alt pins
        st_nxt.oe  = (st_nxt.dir & ~alt_en) | (alt_oe & alt_en);
        st_nxt.drv = (st_nxt.outv & ~alt_en) | (alt_out & alt_en);
        // pull-up only for input, value one, kill clear
        // transitional states decode as-is; the ordering is software's job
        st_nxt.pu  = ~st_nxt.dir & st_nxt.outv & ~{PIN_W{st_nxt.kill}} & ~alt_en;
    end

    // async reset clears drivers, so pins float even without clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r       <= '0;
            st_r.dir   <= gdio_pkg::DIR_RST[PIN_W-1:0];
            st_r.outv  <= gdio_pkg::OUT_RST[PIN_W-1:0];
            st_r.wake  <= gdio_pkg::WAKE_RST[PIN_W-1:0];
            st_r.kill  <= gdio_pkg::KILL_RST;
            st_r.rdata <= gdio_pkg::RDATA_RST;
        end
        else
            st_r <= st_nxt;
    end

    assign prdata  = st_r.rdata;
    assign pready  = st_r.ready;
    assign pslverr = st_r.err;
    assign pin_oe  = st_r.oe;
    assign pin_out = st_r.drv;
    assign pin_pu  = st_r.pu;

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_dir_readback: assert property (
        rd_setup && !pwrite && paddr == gdio_pkg::OFS_DIRECTION
        |=> pready && prdata[PIN_W-1:0] == $past(st_r.dir))
        else $error("direction readback wrong");
    a_kill_blocks_pu: assert property (
        st_r.kill |-> pin_pu == '0)
        else $error("pull-up on while kill set");
    a_dir_drives_oe: assert property (
        ((pin_oe ^ st_r.dir) & ~$past(alt_en)) == '0)
        else $error("driver enable differs from direction");
    a_pullup_decode: assert property (
        pin_pu == (~st_r.dir & st_r.outv & ~{PIN_W{st_r.kill}} & ~$past(alt_en)))
        else $error("pull-up decode wrong");
    a_reset_tristate: assert property (
        @(posedge pclk) disable iff (1'b0) !presetn ##1 !presetn |-> pin_oe == '0 && pin_pu == '0)
        else $error("pin driven during reset");
    a_drive_value: assert property (
        ((pin_out ^ st_r.outv) & st_r.dir & ~$past(alt_en)) == '0)
        else $error("output level differs from value bit");
    a_pin_read: assert property (
        rd_setup && !pwrite && paddr == gdio_pkg::OFS_PIN_INPUT
        |=> prdata[PIN_W-1:0] == $past(sample))
        else $error("pin read wrong");
    a_sync_delay: assert property (
        $stable(sif.level) ##1 $stable(sif.level) |=> sample == $past(sif.level))
        else $error("synchroniser delay wrong");
    a_set_single: assert property (
        wr_go && paddr == gdio_pkg::OFS_DIR_SET |=> st_r.dir == $past(st_r.dir | wmask))
        else $error("set touched other pins");
    a_sleep_clamp: assert property (
        (deep_sleep && st_r.wake == '0 && alt_en == '0)[*3] |-> sample == '0)
        else $error("input not clamped in deep sleep");
    a_kill_write: assert property (
        wr_go && paddr == gdio_pkg::OFS_SYS_CTRL |=> st_r.kill == $past(pwdata[gdio_pkg::KILL_BIT]))
        else $error("kill bit write lost");
    a_reset_clear: assert property (
        @(posedge pclk) disable iff (1'b0) $rose(presetn) |-> st_r.dir == '0 && st_r.outv == '0)
        else $error("config not cleared by reset");

    c_dir_write:  cover property (wr_go && paddr == gdio_pkg::OFS_DIRECTION);
    c_pin_read:   cover property (rd_setup && paddr == gdio_pkg::OFS_PIN_INPUT);
    c_deep_sleep: cover property (deep_sleep && st_r.wake != '0);
    c_kill_on:    cover property (st_r.kill && (~st_r.dir & st_r.outv) != '0);
endmodule : gdio_port
`default_nettype wire

// file: design/gdio_pkg.sv
// shared register map and reset values for the digital io port
package gdio_pkg;
    localparam int        ADDR_W         = 8;
    localparam int        DATA_W         = 32;
    // register byte offsets
    localparam logic [7:0] OFS_DIRECTION = 8'h00;
    localparam logic [7:0] OFS_OUT_VALUE = 8'h04;
    localparam logic [7:0] OFS_PIN_INPUT = 8'h08;
    localparam logic [7:0] OFS_SYS_CTRL  = 8'h0C;
    localparam logic [7:0] OFS_DIR_SET   = 8'h10;
    localparam logic [7:0] OFS_DIR_CLR   = 8'h14;
    localparam logic [7:0] OFS_OUT_SET   = 8'h18;
    localparam logic [7:0] OFS_OUT_CLR   = 8'h1C;
    localparam logic [7:0] OFS_WAKE_KEEP = 8'h20;
    // field positions
    localparam int        KILL_BIT       = 6;
    // reset values
    localparam logic      KILL_RST       = 1'b0;
    localparam logic [31:0] DIR_RST      = 32'h0000_0000;
    localparam logic [31:0] OUT_RST      = 32'h0000_0000;
    localparam logic [31:0] WAKE_RST     = 32'h0000_0000;
    localparam logic [31:0] RDATA_RST    = 32'h0000_0000;
endpackage : gdio_pkg

// file: design/gdio_sync_if.sv
// carrier between the port logic and its input synchroniser
`timescale 1ns/1ps
`default_nettype none
interface gdio_sync_if #(
    parameter int PIN_W = 8
);
    logic [PIN_W-1:0] level;
    logic [PIN_W-1:0] sample;
    modport port_side (output level, input sample);
    modport sync_side (input level, output sample);
endinterface : gdio_sync_if
`default_nettype wire

// file: design/gdio_sync.sv
// two-stage input synchroniser, both stages per pin
`timescale 1ns/1ps
`default_nettype none
module gdio_sync #(
    parameter int PIN_W = 8
) (
    // clock and reset
    input  wire logic    pclk,
    input  wire logic    presetn,
    // pin levels in, samples out
    gdio_sync_if.sync_side sif
);
    logic [PIN_W-1:0] hold_r;
    logic [PIN_W-1:0] sample_r;

    genvar g;
    generate
        for (g = 0; g < PIN_W; g++)
        begin : g_pin
            // closing edge of a latch open while the clock is high;
            // a falling-edge stage avoids a race with the rising-edge stage
            always_ff @(negedge pclk or negedge presetn)
            begin
                if (!presetn)
                    hold_r[g] <= 1'b0;
                else
                    hold_r[g] <= sif.level[g];
            end
            // one period from latch input to sample
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    sample_r[g] <= 1'b0;
                else
                    sample_r[g] <= hold_r[g];
            end
        end
    endgenerate

    assign sif.sample = sample_r;
endmodule : gdio_sync
`default_nettype wire

// file: testbench/gdio_pad_model.sv
// board-side model of the pins: resolves module drive, pull-up and outside drivers
`timescale 1ns/1ps
`default_nettype none
module gdio_pad_model #(
    parameter int PIN_W = 8
) (
    // reference clock for the floating pattern
    input  wire logic             clk,
    // module side of each pad
    input  wire logic [PIN_W-1:0] pin_out,
    input  wire logic [PIN_W-1:0] pin_oe,
    input  wire logic [PIN_W-1:0] pin_pu,
    // outside drivers
    input  wire logic [PIN_W-1:0] ext_en,
    input  wire logic [PIN_W-1:0] ext_val,
    // resolved level
    output logic      [PIN_W-1:0] pin_in
);
    logic [PIN_W-1:0] flt_r = '0;

    // undriven pad without pull-up wanders, so nothing may rely on it
    always @(posedge clk)
        flt_r <= ~flt_r;

    always_comb
    begin
        for (int i = 0; i < PIN_W; i++)
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pin_pu[i] ? 1'b1 : flt_r[i];
    end
endmodule : gdio_pad_model
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the digital io port
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, io_stop, adc_stop, er;
    logic [7:0]  paddr, pin_in, pin_out, pin_oe, pin_pu, alt_en, alt_oe, alt_out, ext_en, ext_val;
    logic [31:0] pwdata, prdata, rd;
    int          err_total = 0;
    int          comparisons = 0;
    int          cycles = 0;
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("Error %s expected %h seen %h", n, e, g); end end

    gdio_port #(.PIN_W(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pu(pin_pu), .io_clk_stop(io_stop),
        .adc_clk_stop(adc_stop), .alt_en(alt_en), .alt_oe(alt_oe), .alt_out(alt_out));
    gdio_pad_model #(.PIN_W(8)) pads (.clk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pu(pin_pu), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

    task automatic print_verdict;
        if (err_total == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    // one apb transfer; the trailing idle edge also gives the synchroniser its cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
        `CHK("pready", 1'b1, pready)
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(nm, e, rd)
    endtask : rchk

    task automatic pins(input logic [7:0] oe, input logic [7:0] drv, input logic [7:0] pu);
        `CHK("pin_oe", oe, pin_oe)
        `CHK("pin_out", drv, pin_out & pin_oe)
        `CHK("pin_pu", pu, pin_pu)
    endtask : pins

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            print_verdict();
        end
    end

    initial
    begin
        {presetn, psel, penable, pwrite, io_stop, adc_stop} = '0;
        {paddr, alt_en, alt_oe, alt_out, ext_en, ext_val} = '0;
        pwdata = '0;
        repeat (4) @(posedge pclk);
        pins(8'h00, 8'h00, 8'h00);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(gdio_pkg::OFS_DIRECTION, 32'h0000_0000, "dir reset");
        rchk(gdio_pkg::OFS_OUT_VALUE, 32'h0000_0000, "out reset");
        rchk(gdio_pkg::OFS_SYS_CTRL, 32'h0000_0000, "ctrl reset");
        ext_en <= 8'h30;
        ext_val <= 8'h10;
        // each pin steps 00-10-11, 00-10 or 00-01, or stays 00, never a direct jump
        apb(1'b1, gdio_pkg::OFS_DIRECTION, 32'h0000_000F);
        apb(1'b1, gdio_pkg::OFS_OUT_VALUE, 32'h0000_00C3);
        pins(8'h0F, 8'h03, 8'hC0);
        rchk(gdio_pkg::OFS_PIN_INPUT, 32'h0000_00D3, "pin input");
        apb(1'b1, gdio_pkg::OFS_SYS_CTRL, 32'h0000_00FF);
        pins(8'h0F, 8'h03, 8'h00);
        rchk(gdio_pkg::OFS_SYS_CTRL, 32'h0000_0040, "kill bit");
        apb(1'b1, gdio_pkg::OFS_SYS_CTRL, 32'h0000_0000);
        pins(8'h0F, 8'h03, 8'hC0);
        ext_en <= 8'h20;
        apb(1'b1, gdio_pkg::OFS_DIR_SET, 32'h0000_0010);
        apb(1'b1, gdio_pkg::OFS_OUT_SET, 32'h0000_0010);
        apb(1'b1, gdio_pkg::OFS_OUT_CLR, 32'h0000_0001);
        apb(1'b1, gdio_pkg::OFS_DIR_CLR, 32'h0000_0001);
        pins(8'h1E, 8'h12, 8'hC0);
        rchk(gdio_pkg::OFS_DIRECTION, 32'h0000_001E, "dir bits");
        rchk(gdio_pkg::OFS_OUT_VALUE, 32'h0000_00D2, "out bits");
        apb(1'b1, 8'h40, 32'h0000_00FF);
        `CHK("slverr wr", 1'b1, er)
        rchk(8'h40, 32'h0000_0000, "unmapped");
        `CHK("slverr rd", 1'b1, er)
        apb(1'b1, gdio_pkg::OFS_WAKE_KEEP, 32'h0000_0002);
        io_stop <= 1'b1;
        adc_stop <= 1'b1;
        repeat (2) @(posedge pclk);
        rchk(gdio_pkg::OFS_PIN_INPUT, 32'h0000_0002, "sleep input");
        io_stop <= 1'b0;
        adc_stop <= 1'b0;
        alt_en <= 8'h80;
        alt_oe <= 8'h80;
        repeat (3) @(posedge pclk);
        pins(8'h9E, 8'h12, 8'h40);
        rchk(gdio_pkg::OFS_DIRECTION, 32'h0000_001E, "dir alt");
        alt_en <= 8'h00;
        @(posedge pclk);
        presetn <= 1'b0;
        #1;
        pins(8'h00, 8'h00, 8'h00);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(gdio_pkg::OFS_OUT_VALUE, 32'h0000_0000, "out rerst");
        print_verdict();
    end
endmodule : tb
`default_nettype wire
